/* hdl/acc_pkg.sv */
// Package for the analog comparator control block: register map, field positions,
// reset values and interrupt mode encodings.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package acc_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CMP_CTRL_STATUS = 8'h30;
	localparam logic [7:0] OFS_CONV_CTRL_B = 8'h34;
	localparam logic [7:0] OFS_DIN_DISABLE = 8'h38;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h3C;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h40;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h44;

	// ------------------------------------------------------------
	// Field positions in the control and status, converter control B, input-disable and interrupt registers
	// ------------------------------------------------------------
	localparam int BIT_POWER_OFF = 7;
	localparam int BIT_BANDGAP = 6;
	localparam int BIT_RESULT = 5;
	localparam int BIT_FLAG = 4;
	localparam int BIT_IRQ_EN = 3;
	localparam int BIT_CAPTURE = 2;
	localparam int BIT_MODE_HI = 1;
	localparam int BIT_MODE_LO = 0;
	localparam int BIT_MUX_ENABLE = 6;
	localparam int BIT_NEG_IN_OFF = 1;
	localparam int BIT_POS_IN_OFF = 0;
	localparam int NUM_IRQ_SRC = 2;
	localparam int SRC_CMP_EVENT = 0;
	localparam int SRC_RESULT_CHANGE = 1;

	// ------------------------------------------------------------
	// Reset values and bus answers
	// ------------------------------------------------------------
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [1:0] RST_DIN_OFF = 2'h0;
	localparam logic [1:0] RST_IRQ = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Interrupt mode encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_TOGGLE = 2'h0,
		MODE_RESERVED = 2'h1,
		MODE_FALL = 2'h2,
		MODE_RISE = 2'h3
	} acc_mode_t;

endpackage : acc_pkg

/* hdl/acc_sync2.sv */
// Two-flop level synchroniser.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/100ps
`default_nettype none
module acc_sync2 (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Level in and out
	input wire logic d,
	output logic q
);
	logic meta_reg;

	// First stage feeds the second and nothing else
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : acc_sync2
`default_nettype wire

/* hdl/acc_edge_detect.sv */
// Edge detector on an already synchronised level, with mode selection.
// Assumes the sample input is synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module acc_edge_detect (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Sample and mode
	input wire logic sample,
	input wire acc_pkg::acc_mode_t mode,
	// Results
	output logic toggle,
	output logic event_hit
);
	logic prev_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= sample;
		end
	end

	assign toggle = sample ^ prev_reg;

	always_comb begin
		case (mode)
			acc_pkg::MODE_TOGGLE: event_hit = toggle;
			acc_pkg::MODE_FALL: event_hit = toggle & ~sample;
			acc_pkg::MODE_RISE: event_hit = toggle & sample;
			default: event_hit = 1'b0;
		endcase
	end
endmodule : acc_edge_detect
`default_nettype wire

/* hdl/acc_top.sv */
// Control and status logic around an analog comparator, reached over AXI4-Lite.
// Assumes the comparator core, input multiplexer and timer capture sit outside;
// the converter enable, channel select, global enable and vector acknowledge are inputs.
//
// Overview of operation
// - Raw result is synchronised before it shows as the result bit.
// - Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - Flag in bit 4 sets on an event matching the selected mode.
// - Flag clears on vector taken or on software writing one.
// - Interrupt request only while local enable, global enable and flag are set.
// - Power-off bit 7 switches the comparator off; settable any time.
// - Bandgap select bit 6 puts the reference on the positive input.
// - Capture-enable bit 2 routes the result to the timer capture front end.
// - Mux enabled and converter off: channel select picks converter pin 0 to 7.
// - Mux disabled or converter on: dedicated negative pin is used.
// - Mux-enable control sits at bit 6 of converter control register B.
// - Input-disable bits 1 and 0 turn off buffers; port bit reads zero.
`timescale 1ns/100ps
`default_nettype none
module acc_top (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RSTN,
	// AXI4-Lite write address and data
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// AXI4-Lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Comparator core
	input wire logic CMP_RAW,
	output logic CMP_POWER_OFF,
	output logic BANDGAP_POSITIVE,
	output logic NEG_USE_MUX,
	output logic [2:0] NEG_CHANNEL,
	// Neighbouring units
	input wire logic CONVERTER_ENABLE,
	input wire logic [2:0] CHANNEL_SELECT,
	input wire logic GLOBAL_IRQ_ENABLE,
	input wire logic VECTOR_TAKEN,
	output logic CAPTURE_OUT,
	output logic CMP_IRQ_REQ,
	// Comparator pins, digital side
	input wire logic [1:0] PIN_DIN,
	output logic [1:0] PIN_INPUT_OFF,
	output logic [1:0] PIN_READ,
	// Block interrupt
	output logic IRQ
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// Result synchronisation and edge detection
	// ------------------------------------------------------------
	logic cmp_result_sync;
	logic result_toggle;
	logic cmp_event;
	logic cmp_power_off_reg;
	logic bandgap_positive_select_reg;
	logic cmp_event_flag_reg;
	logic cmp_irq_enable_reg;
	logic capture_route_enable_reg;
	acc_pkg::acc_mode_t irq_mode_reg;
	logic negative_mux_enable_reg;
	logic [1:0] din_off_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_enable_reg;

	acc_sync2 u_sync (
		.clk(CLOCK),
		.rst_n(rst_n),
		.d(CMP_RAW),
		.q(cmp_result_sync)
	);

	// Edges come only from the synchronised copy, never the raw input
	acc_edge_detect u_edge (
		.clk(CLOCK),
		.rst_n(rst_n),
		.sample(cmp_result_sync),
		.mode(irq_mode_reg),
		.toggle(result_toggle),
		.event_hit(cmp_event)
	);

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic aw_have_reg;
	logic w_have_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_do;
	logic aw_have_next;
	logic w_have_next;
	logic bvalid_next;
	logic [31:0] rd_word;
	logic rd_ok;

	// Write happens one cycle after both halves are held; response rises on the same edge
	assign wr_do = aw_have_reg & w_have_reg & ~BVALID;

	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		bvalid_next = BVALID;
		if (AWVALID && AWREADY)
			aw_have_next = 1'b1;
		if (WVALID && WREADY)
			w_have_next = 1'b1;
		if (wr_do) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
		end else if (BVALID && BREADY) begin
			bvalid_next = 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			BVALID <= 1'b0;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			BVALID <= bvalid_next;
			AWREADY <= ~aw_have_next & ~bvalid_next;
			WREADY <= ~w_have_next & ~bvalid_next;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			BRESP <= acc_pkg::RESP_OKAY;
		end else begin
			if (AWVALID && AWREADY)
				awaddr_reg <= AWADDR;
			if (WVALID && WREADY) begin
				wdata_reg <= WDATA;
				wstrb_reg <= WSTRB;
			end
			if (wr_do) begin
				case (awaddr_reg)
					acc_pkg::OFS_CMP_CTRL_STATUS, acc_pkg::OFS_CONV_CTRL_B, acc_pkg::OFS_DIN_DISABLE,
					acc_pkg::OFS_IRQ_STATUS, acc_pkg::OFS_IRQ_CLEAR, acc_pkg::OFS_IRQ_ENABLE:
						BRESP <= acc_pkg::RESP_OKAY;
					default: BRESP <= acc_pkg::RESP_SLVERR;
				endcase
			end
		end
	end

	logic wr_lane0;
	assign wr_lane0 = wr_do & wstrb_reg[0];

	always_comb begin
		rd_ok = 1'b1;
		rd_word = 32'h0000_0000;
		case (ARADDR)
			acc_pkg::OFS_CMP_CTRL_STATUS: begin
				rd_word[acc_pkg::BIT_POWER_OFF] = cmp_power_off_reg;
				rd_word[acc_pkg::BIT_BANDGAP] = bandgap_positive_select_reg;
				rd_word[acc_pkg::BIT_RESULT] = cmp_result_sync;
				rd_word[acc_pkg::BIT_FLAG] = cmp_event_flag_reg;
				rd_word[acc_pkg::BIT_IRQ_EN] = cmp_irq_enable_reg;
				rd_word[acc_pkg::BIT_CAPTURE] = capture_route_enable_reg;
				rd_word[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO] = irq_mode_reg;
			end
			acc_pkg::OFS_CONV_CTRL_B: rd_word[acc_pkg::BIT_MUX_ENABLE] = negative_mux_enable_reg;
			acc_pkg::OFS_DIN_DISABLE: rd_word[1:0] = din_off_reg;
			acc_pkg::OFS_IRQ_STATUS: rd_word[1:0] = irq_status_reg;
			acc_pkg::OFS_IRQ_CLEAR: rd_word = 32'h0000_0000;
			acc_pkg::OFS_IRQ_ENABLE: rd_word[1:0] = irq_enable_reg;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= acc_pkg::RESP_OKAY;
		end else begin
			if (ARVALID && ARREADY) begin
				ARREADY <= 1'b0;
				RVALID <= 1'b1;
				RDATA <= rd_word;
				RRESP <= rd_ok ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
				ARREADY <= 1'b1;
			end else if (!RVALID) begin
				ARREADY <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Mode and power changes are not gated by the enable; software disables first
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			cmp_power_off_reg <= acc_pkg::RST_CTRL[acc_pkg::BIT_POWER_OFF];
			bandgap_positive_select_reg <= acc_pkg::RST_CTRL[acc_pkg::BIT_BANDGAP];
			cmp_irq_enable_reg <= acc_pkg::RST_CTRL[acc_pkg::BIT_IRQ_EN];
			capture_route_enable_reg <= acc_pkg::RST_CTRL[acc_pkg::BIT_CAPTURE];
			irq_mode_reg <= acc_pkg::MODE_TOGGLE;
			negative_mux_enable_reg <= acc_pkg::RST_CTRL[acc_pkg::BIT_MUX_ENABLE];
			din_off_reg <= acc_pkg::RST_DIN_OFF;
			irq_enable_reg <= acc_pkg::RST_IRQ;
		end else if (wr_lane0) begin
			case (awaddr_reg)
				acc_pkg::OFS_CMP_CTRL_STATUS: begin
					cmp_power_off_reg <= wdata_reg[acc_pkg::BIT_POWER_OFF];
					bandgap_positive_select_reg <= wdata_reg[acc_pkg::BIT_BANDGAP];
					cmp_irq_enable_reg <= wdata_reg[acc_pkg::BIT_IRQ_EN];
					capture_route_enable_reg <= wdata_reg[acc_pkg::BIT_CAPTURE];
					irq_mode_reg <= acc_pkg::acc_mode_t'(wdata_reg[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO]);
				end
				acc_pkg::OFS_CONV_CTRL_B: negative_mux_enable_reg <= wdata_reg[acc_pkg::BIT_MUX_ENABLE];
				acc_pkg::OFS_DIN_DISABLE: din_off_reg <= wdata_reg[1:0];
				acc_pkg::OFS_IRQ_ENABLE: irq_enable_reg <= wdata_reg[1:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Event flag and interrupt status
	// ------------------------------------------------------------
	logic flag_wr_clear;
	logic [1:0] status_clear;
	logic [1:0] status_set;

	assign flag_wr_clear = wr_lane0 && awaddr_reg == acc_pkg::OFS_CMP_CTRL_STATUS
		&& wdata_reg[acc_pkg::BIT_FLAG];
	assign status_clear = (wr_lane0 && awaddr_reg == acc_pkg::OFS_IRQ_CLEAR) ? wdata_reg[1:0] : 2'h0;
	assign status_set = {result_toggle, cmp_event};

	// A new event in the clearing cycle wins so no edge is lost
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			cmp_event_flag_reg <= acc_pkg::RST_CTRL[acc_pkg::BIT_FLAG];
		end else if (cmp_event) begin
			cmp_event_flag_reg <= 1'b1;
		end else if (VECTOR_TAKEN || flag_wr_clear) begin
			cmp_event_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_reg <= acc_pkg::RST_IRQ;
		end else begin
			irq_status_reg <= (irq_status_reg & ~status_clear) | status_set;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			CMP_IRQ_REQ <= 1'b0;
			IRQ <= 1'b0;
			CMP_POWER_OFF <= 1'b0;
			BANDGAP_POSITIVE <= 1'b0;
			CAPTURE_OUT <= 1'b0;
			NEG_USE_MUX <= 1'b0;
			NEG_CHANNEL <= 3'h0;
			PIN_INPUT_OFF <= 2'h0;
			PIN_READ <= 2'h0;
		end else begin
			CMP_IRQ_REQ <= cmp_event_flag_reg & cmp_irq_enable_reg & GLOBAL_IRQ_ENABLE;
			IRQ <= |(irq_status_reg & irq_enable_reg);
			CMP_POWER_OFF <= cmp_power_off_reg;
			BANDGAP_POSITIVE <= bandgap_positive_select_reg;
			CAPTURE_OUT <= capture_route_enable_reg & cmp_result_sync;
			NEG_USE_MUX <= negative_mux_enable_reg & ~CONVERTER_ENABLE;
			NEG_CHANNEL <= (negative_mux_enable_reg & ~CONVERTER_ENABLE) ? CHANNEL_SELECT : 3'h0;
			PIN_INPUT_OFF <= din_off_reg;
			PIN_READ <= PIN_DIN & ~din_off_reg;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!rst_n);

	property p_sync_delay;
		$past(rst_n, 2) |-> cmp_result_sync == $past(CMP_RAW, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("result not two cycles behind raw");

	property p_rise_sets;
		($rose(cmp_result_sync) && irq_mode_reg == acc_pkg::MODE_RISE) |=> cmp_event_flag_reg;
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rising edge did not set flag");

	property p_fall_ignores_rise;
		($rose(cmp_result_sync) && irq_mode_reg == acc_pkg::MODE_FALL && !cmp_event_flag_reg
			&& !(wr_lane0 && awaddr_reg == acc_pkg::OFS_CMP_CTRL_STATUS)) |=> !cmp_event_flag_reg;
	endproperty
	a_fall_ignores_rise: assert property (p_fall_ignores_rise) else $error("rise set flag in fall mode");

	property p_reserved_quiet;
		(irq_mode_reg == acc_pkg::MODE_RESERVED && !cmp_event_flag_reg && !wr_do) |=> !cmp_event_flag_reg;
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet) else $error("flag set in reserved mode");

	property p_ack_clears;
		(VECTOR_TAKEN && !cmp_event) |=> !cmp_event_flag_reg;
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("vector taken did not clear flag");

	property p_irq_req;
		(cmp_event_flag_reg && cmp_irq_enable_reg && GLOBAL_IRQ_ENABLE) |=> CMP_IRQ_REQ;
	endproperty
	a_irq_req: assert property (p_irq_req) else $error("request missing while pending and enabled");

	property p_irq_gated;
		!GLOBAL_IRQ_ENABLE |=> !CMP_IRQ_REQ;
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("request without global enable");

	property p_pin_zero;
		din_off_reg[0] |=> !PIN_READ[0];
	endproperty
	a_pin_zero: assert property (p_pin_zero) else $error("disabled pin read non-zero");

	property p_neg_pin;
		(!negative_mux_enable_reg || CONVERTER_ENABLE) |=> !NEG_USE_MUX;
	endproperty
	a_neg_pin: assert property (p_neg_pin) else $error("mux used while converter on or mux off");

	property p_capture_off;
		!capture_route_enable_reg |=> !CAPTURE_OUT;
	endproperty
	a_capture_off: assert property (p_capture_off) else $error("capture driven while route off");

	property p_power;
		cmp_power_off_reg |=> CMP_POWER_OFF ##0 $past(bandgap_positive_select_reg) == BANDGAP_POSITIVE;
	endproperty
	a_power: assert property (p_power) else $error("power or bandgap output lags control");

	c_rise_flag: cover property (irq_mode_reg == acc_pkg::MODE_RISE ##1 cmp_event_flag_reg);
	c_irq_req: cover property (CMP_IRQ_REQ ##1 VECTOR_TAKEN);
	c_mux_used: cover property (NEG_USE_MUX && NEG_CHANNEL == 3'h7);
	c_block_irq: cover property (IRQ);

endmodule : acc_top
`default_nettype wire

/* verif/acc_cmp_model.sv */
// Behavioural model of the comparator core and its input multiplexers.
// Assumes the bench sets analog levels as integers; a higher positive level gives one.
`timescale 1ns/100ps
`default_nettype none
module acc_cmp_model (
	// Controls from the block
	input wire logic power_off,
	input wire logic bandgap_sel,
	input wire logic use_mux,
	input wire logic [2:0] channel,
	// Analog levels
	input var int pos_lvl,
	input var int neg_lvl,
	input var int bg_lvl,
	input var int chan_lvl [8],
	// Raw result
	output logic raw
);
	int p;
	int n;
	always_comb begin
		p = bandgap_sel ? bg_lvl : pos_lvl;
		n = use_mux ? chan_lvl[channel] : neg_lvl;
		// A core without power has no valid answer; low keeps it inactive
		raw = power_off ? 1'b0 : (p > n);
	end
endmodule : acc_cmp_model
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the comparator control block.
// Assumes AXI4-Lite byte addresses and the comparator model beside the block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic CLOCK = 1'b0;
	logic RSTN = 1'b0;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic [31:0] WDATA = 32'h0000_0000;
	logic [3:0] WSTRB = 4'hf;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CMP_RAW, CMP_POWER_OFF, BANDGAP_POSITIVE;
	logic [1:0] BRESP, RRESP, PIN_INPUT_OFF, PIN_READ;
	logic [31:0] RDATA;
	logic NEG_USE_MUX, CAPTURE_OUT, CMP_IRQ_REQ, IRQ;
	logic [2:0] NEG_CHANNEL;
	logic CONVERTER_ENABLE = 1'b0, GLOBAL_IRQ_ENABLE = 1'b0, VECTOR_TAKEN = 1'b0;
	logic [2:0] CHANNEL_SELECT = 3'h0;
	logic [1:0] PIN_DIN = 2'h0;
	int pos_lvl = 0, neg_lvl = 50, bg_lvl = 100;
	int chan_lvl [8] = '{default: 0};
	int err_count = 0, cmp_count = 0, cyc = 0, seed = 84;

	always #4 CLOCK = ~CLOCK;

	acc_top i_acc_top (.CLOCK(CLOCK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
		.RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .CMP_RAW(CMP_RAW), .CMP_POWER_OFF(CMP_POWER_OFF),
		.BANDGAP_POSITIVE(BANDGAP_POSITIVE), .NEG_USE_MUX(NEG_USE_MUX), .NEG_CHANNEL(NEG_CHANNEL),
		.CONVERTER_ENABLE(CONVERTER_ENABLE), .CHANNEL_SELECT(CHANNEL_SELECT),
		.GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .VECTOR_TAKEN(VECTOR_TAKEN), .CAPTURE_OUT(CAPTURE_OUT),
		.CMP_IRQ_REQ(CMP_IRQ_REQ), .PIN_DIN(PIN_DIN), .PIN_INPUT_OFF(PIN_INPUT_OFF), .PIN_READ(PIN_READ),
		.IRQ(IRQ));

	acc_cmp_model i_acc_cmp_model (.power_off(CMP_POWER_OFF), .bandgap_sel(BANDGAP_POSITIVE),
		.use_mux(NEG_USE_MUX), .channel(NEG_CHANNEL), .pos_lvl(pos_lvl), .neg_lvl(neg_lvl),
		.bg_lvl(bg_lvl), .chan_lvl(chan_lvl), .raw(CMP_RAW));

	// ------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Long enough for every scenario with wide margin
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge CLOCK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge CLOCK);
			if (AWVALID && AWREADY === 1'b1) begin
				aw_ok = 1'b1;
				AWVALID <= 1'b0;
			end
			if (WVALID && WREADY === 1'b1) begin
				w_ok = 1'b1;
				WVALID <= 1'b0;
			end
		end
		do @(posedge CLOCK); while (BVALID !== 1'b1);
		rsp = BRESP;
		BREADY <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
		@(posedge CLOCK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do @(posedge CLOCK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge CLOCK); while (RVALID !== 1'b1);
		d = RDATA;
		rsp = RRESP;
		RREADY <= 1'b0;
	endtask : rd

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] ofs [5];
		int me, ce, c, en, off;
		ofs = '{acc_pkg::OFS_CMP_CTRL_STATUS, acc_pkg::OFS_CONV_CTRL_B, acc_pkg::OFS_DIN_DISABLE,
			acc_pkg::OFS_IRQ_STATUS, acc_pkg::OFS_IRQ_ENABLE};
		tick(3);
		RSTN <= 1'b1;
		tick(4);
		foreach (ofs[i]) begin
			rd(ofs[i], d, r);
			chk("reset value", 32'h0000_0000, d);
			chk("reset resp", acc_pkg::RESP_OKAY, r);
		end
		rd(8'h50, d, r);
		chk("unmapped read", {30'h0, acc_pkg::RESP_SLVERR}, {d[29:0], r});
		wr(8'h50, 32'h0000_00ff, r);
		chk("unmapped write", acc_pkg::RESP_SLVERR, r);
		// Interrupt enable stays off across every mode change
		for (int m = 0; m < 4; m++) begin
			wr(acc_pkg::OFS_CMP_CTRL_STATUS, 32'h0000_0010 | m, r);
			pos_lvl <= 100;
			tick(6);
			rd(acc_pkg::OFS_CMP_CTRL_STATUS, d, r);
			chk("flag on rise", (m == 0 || m == 3), d[4]);
			chk("result high", 1, d[5]);
			chk("capture off", 0, CAPTURE_OUT);
			wr(acc_pkg::OFS_CMP_CTRL_STATUS, 32'h0000_0010 | m, r);
			rd(acc_pkg::OFS_CMP_CTRL_STATUS, d, r);
			chk("flag cleared", 0, d[4]);
			pos_lvl <= 0;
			tick(6);
			rd(acc_pkg::OFS_CMP_CTRL_STATUS, d, r);
			chk("flag on fall", (m == 0 || m == 2), d[4]);
		end
		// Request needs flag, local and global enable
		wr(acc_pkg::OFS_IRQ_CLEAR, 32'h0000_0003, r);
		wr(acc_pkg::OFS_CMP_CTRL_STATUS, 32'h0000_001f, r);
		wr(acc_pkg::OFS_IRQ_ENABLE, 32'h0000_0001, r);
		pos_lvl <= 100;
		tick(6);
		chk("req no global", 0, CMP_IRQ_REQ);
		chk("capture on", 1, CAPTURE_OUT);
		chk("irq line", 1, IRQ);
		rd(acc_pkg::OFS_IRQ_STATUS, d, r);
		chk("irq status", 32'h0000_0003, d);
		// Only the result-change source is enabled; it is still pending
		wr(acc_pkg::OFS_IRQ_ENABLE, 32'h0000_0002, r);
		tick(2);
		chk("irq bit1", 1, IRQ);
		wr(acc_pkg::OFS_IRQ_CLEAR, 32'h0000_0002, r);
		tick(2);
		chk("irq masked", 0, IRQ);
		wr(acc_pkg::OFS_IRQ_CLEAR, 32'h0000_0003, r);
		rd(acc_pkg::OFS_IRQ_STATUS, d, r);
		chk("irq cleared", 32'h0000_0000, d);
		GLOBAL_IRQ_ENABLE <= 1'b1;
		tick(2);
		chk("req set", 1, CMP_IRQ_REQ);
		VECTOR_TAKEN <= 1'b1;
		tick(1);
		VECTOR_TAKEN <= 1'b0;
		tick(3);
		chk("req after vector", 0, CMP_IRQ_REQ);
		// Enable off before the power and reference changes
		wr(acc_pkg::OFS_CMP_CTRL_STATUS, 32'h0000_0000, r);
		wr(acc_pkg::OFS_CMP_CTRL_STATUS, 32'h0000_00c0, r);
		tick(2);
		chk("power off", 2'b11, {CMP_POWER_OFF, BANDGAP_POSITIVE});
		pos_lvl <= 0;
		wr(acc_pkg::OFS_CMP_CTRL_STATUS, 32'h0000_0040, r);
		tick(6);
		rd(acc_pkg::OFS_CMP_CTRL_STATUS, d, r);
		// Toggle mode: power-off fall and bandgap rise both set the flag
		chk("bandgap result", 32'h0000_0070, d);
		wr(acc_pkg::OFS_CMP_CTRL_STATUS, 32'h0000_0010, r);
		pos_lvl <= 100;
		for (int i = 0; i < 24; i++) begin
			me = $random(seed) & 1;
			ce = $random(seed) & 1;
			c = $random(seed) & 7;
			en = me && !ce;
			foreach (chan_lvl[k]) chan_lvl[k] <= (k == c) ? 150 : 0;
			CONVERTER_ENABLE <= ce[0];
			CHANNEL_SELECT <= c[2:0];
			wr(acc_pkg::OFS_CONV_CTRL_B, me << acc_pkg::BIT_MUX_ENABLE, r);
			tick(6);
			chk("mux use", en, NEG_USE_MUX);
			chk("mux channel", en ? c : 0, NEG_CHANNEL);
			rd(acc_pkg::OFS_CMP_CTRL_STATUS, d, r);
			chk("mux result", !en, d[5]);
		end
		// Analog pins get their buffers off when the digital value is unused
		for (int i = 0; i < 8; i++) begin
			off = $random(seed) & 3;
			PIN_DIN <= 2'($random(seed));
			wr(acc_pkg::OFS_DIN_DISABLE, off, r);
			tick(3);
			chk("pin off", off, PIN_INPUT_OFF);
			chk("pin read", PIN_DIN & ~off[1:0], PIN_READ);
			rd(acc_pkg::OFS_DIN_DISABLE, d, r);
			chk("pin off reg", off, d);
		end
		conclude();
	end
endmodule : testbench
`default_nettype wire
